/* File: include/pad_pkg.sv */
// Functional notes
// - Codes 0-2 drive outputs in logic mode
// - Code 4 gates power with hardware enable
// - Unprogrammed code 4: hardware enable alone
// - Codes 5/6 jog reverse/forward when enabled
// - Both jog directions active: stop motor
// - Code 8 true stops the motor
// - Code 18 permits jogging, false inhibits
// - Code 19 true raises logic fault
// - Code 20 follows forward motion enable
// - Code 21 follows reverse motion enable
// - Code 22 selects accel group two
// - Code 23 resets once per rising edge
// - Code 24 picks preset table or source
// - Defaults: command source, first preset entry
// - Codes 25-27 drive preset index bits
// - Unprogrammed index bits held at zero
package pad_pkg;
  localparam int ACT_W = 8;
  localparam int NUM_ACT = 28;
  localparam logic [ACT_W-1:0] ACT_LIMIT = 8'h1C;
  localparam int ACT_DOUT1 = 0;
  localparam int ACT_DOUT2 = 1;
  localparam int ACT_RELAY1 = 2;
  localparam int ACT_DRV_EN = 4;
  localparam int ACT_JOG_REV = 5;
  localparam int ACT_JOG_FWD = 6;
  localparam int ACT_STOP = 8;
  localparam int ACT_JOG_EN = 18;
  localparam int ACT_FAULT = 19;
  localparam int ACT_FWD_EN = 20;
  localparam int ACT_REV_EN = 21;
  localparam int ACT_ACC_GRP = 22;
  localparam int ACT_RESET = 23;
  localparam int ACT_PRESET = 24;
  localparam int ACT_IDX0 = 25;
  localparam int IDX_W = 3;
  localparam int SRC_SEL_W = 4;
  localparam logic [SRC_SEL_W-1:0] SRC_SEL_LOGIC = 4'h1;
  localparam int SPEED_W = 16;
  localparam int PRESET_AW = 4;
  localparam logic [SPEED_W-1:0] RST_SPEED = 16'h0000;
  localparam logic [NUM_ACT-1:0] RST_ACT = 28'h0000000;

  typedef struct packed {
    logic valid;
    logic [ACT_W-1:0] code;
    logic cond;
  } pad_rule_res_t;

  typedef struct packed {
    logic drive_en;
    logic jog_fwd;
    logic jog_rev;
    logic stop;
    logic fwd_en;
    logic rev_en;
    logic acc_grp2;
  } pad_motion_t;

  localparam pad_motion_t RST_MOTION = 7'h00;
endpackage

/* File: core/pad_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pad_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_q
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* File: core/pad_preset_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module pad_preset_mem #(
  parameter int AW = 4,
  parameter int W = 16
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data_q
);
  logic [W-1:0] mem [0:(1<<AW)-1];

  // Array has no reset; configuration loads it
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

/* File: core/pad_dispatcher.sv */
`timescale 1ns/1ps
`default_nettype none
module pad_dispatcher (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire pad_pkg::pad_rule_res_t rule_res,
  input wire logic scan_done,
  input wire logic [pad_pkg::SRC_SEL_W-1:0] digital_out1_source_sel,
  input wire logic [pad_pkg::SRC_SEL_W-1:0] digital_out2_source_sel,
  input wire logic [pad_pkg::SRC_SEL_W-1:0] relay_out1_source_sel,
  input wire logic hardware_enable_input,
  input wire logic external_trip_config,
  input wire logic [pad_pkg::SPEED_W-1:0] jog_speed_setting,
  input wire logic [pad_pkg::SPEED_W-1:0] cmd_speed_ref,
  input wire logic preset_wr_en,
  input wire logic [pad_pkg::PRESET_AW-1:0] preset_wr_addr,
  input wire logic [pad_pkg::SPEED_W-1:0] preset_wr_data,
  output logic digital_out1_q,
  output logic digital_out2_q,
  output logic relay_out1_q,
  output logic [2:0] out_owned_q,
  output pad_pkg::pad_motion_t motion_q,
  output logic [pad_pkg::SPEED_W-1:0] jog_speed_q,
  output logic logic_fault_q,
  output logic trip_conflict_q,
  output logic reset_req_q,
  output logic speed_from_preset_q,
  output logic [pad_pkg::IDX_W-1:0] preset_index_q,
  output logic [pad_pkg::SPEED_W-1:0] speed_ref_q
);
  import pad_pkg::*;

  logic [NUM_ACT-1:0] hit_vec;
  logic [NUM_ACT-1:0] acc_cond_q;
  logic [NUM_ACT-1:0] acc_prog_q;
  logic [NUM_ACT-1:0] nxt_cond;
  logic [NUM_ACT-1:0] nxt_prog;
  logic [NUM_ACT-1:0] act_cond_q;
  logic [NUM_ACT-1:0] act_prog_q;
  logic hw_en_s;
  logic jog_allow;
  logic jog_f;
  logic jog_r;
  logic jog_clash;
  logic use_preset;
  logic [IDX_W-1:0] idx;
  logic [SPEED_W-1:0] preset_rd;
  pad_motion_t motion_d;

  // Enable pin comes from outside the clock domain
  pad_sync #(
    .W(1)
  ) u_en_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .async_in(hardware_enable_input),
    .sync_q(hw_en_s)
  );

  // Decode one evaluated rule; codes 28 and up pass by
  always_comb begin
    hit_vec = '0;
    if (rule_res.valid && (rule_res.code < ACT_LIMIT)) begin
      hit_vec = NUM_ACT'(1) << rule_res.code[4:0];
    end
    // Several rules on one action are ORed
    nxt_prog = acc_prog_q | hit_vec;
    nxt_cond = acc_cond_q | (rule_res.cond ? hit_vec : '0);
  end

  // Scan accumulator; a rule in the done cycle still counts
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      acc_cond_q <= RST_ACT;
      acc_prog_q <= RST_ACT;
    end else if (scan_done) begin
      acc_cond_q <= RST_ACT;
      acc_prog_q <= RST_ACT;
    end else begin
      acc_cond_q <= nxt_cond;
      acc_prog_q <= nxt_prog;
    end
  end

  // Whole scan applied at once, so actions never see half a scan
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      act_cond_q <= RST_ACT;
      act_prog_q <= RST_ACT;
    end else if (scan_done) begin
      act_cond_q <= nxt_cond;
      act_prog_q <= nxt_prog;
    end
  end

  // Rising edge seen across scans gives one request
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reset_req_q <= 1'b0;
    end else begin
      reset_req_q <= scan_done && nxt_cond[ACT_RESET] && !act_cond_q[ACT_RESET];
    end
  end

  // Discrete outputs only when their source selects logic mode
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      digital_out1_q <= 1'b0;
      digital_out2_q <= 1'b0;
      relay_out1_q <= 1'b0;
      out_owned_q <= 3'h0;
    end else begin
      out_owned_q[0] <= (digital_out1_source_sel == SRC_SEL_LOGIC);
      out_owned_q[1] <= (digital_out2_source_sel == SRC_SEL_LOGIC);
      out_owned_q[2] <= (relay_out1_source_sel == SRC_SEL_LOGIC);
      digital_out1_q <= (digital_out1_source_sel == SRC_SEL_LOGIC) &&
                        act_cond_q[ACT_DOUT1];
      digital_out2_q <= (digital_out2_source_sel == SRC_SEL_LOGIC) &&
                        act_cond_q[ACT_DOUT2];
      relay_out1_q <= (relay_out1_source_sel == SRC_SEL_LOGIC) &&
                      act_cond_q[ACT_RELAY1];
    end
  end

  // Motion controls
  always_comb begin
    // Unprogrammed jog enable leaves jogging allowed
    jog_allow = !act_prog_q[ACT_JOG_EN] || act_cond_q[ACT_JOG_EN];
    jog_f = act_cond_q[ACT_JOG_FWD] && jog_allow;
    jog_r = act_cond_q[ACT_JOG_REV] && jog_allow;
    jog_clash = jog_f && jog_r;
    motion_d.drive_en = hw_en_s &&
                        (!act_prog_q[ACT_DRV_EN] || act_cond_q[ACT_DRV_EN]);
    motion_d.jog_fwd = jog_f && !jog_clash;
    motion_d.jog_rev = jog_r && !jog_clash;
    motion_d.stop = act_cond_q[ACT_STOP] || jog_clash;
    // Unprogrammed direction enables leave motion allowed
    motion_d.fwd_en = !act_prog_q[ACT_FWD_EN] || act_cond_q[ACT_FWD_EN];
    motion_d.rev_en = !act_prog_q[ACT_REV_EN] || act_cond_q[ACT_REV_EN];
    motion_d.acc_grp2 = act_prog_q[ACT_ACC_GRP] && act_cond_q[ACT_ACC_GRP];
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      motion_q <= RST_MOTION;
      jog_speed_q <= RST_SPEED;
    end else begin
      motion_q <= motion_d;
      jog_speed_q <= jog_speed_setting;
    end
  end

  // Fault and trip configuration check
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      logic_fault_q <= 1'b0;
      trip_conflict_q <= 1'b0;
    end else begin
      logic_fault_q <= act_prog_q[ACT_FAULT] && act_cond_q[ACT_FAULT];
      // Flag only; the configuration must resolve it
      trip_conflict_q <= act_prog_q[ACT_FAULT] && external_trip_config;
    end
  end

  // Index bits default to zero when not programmed
  always_comb begin
    for (int i = 0; i < IDX_W; i++) begin
      idx[i] = act_prog_q[ACT_IDX0+i] && act_cond_q[ACT_IDX0+i];
    end
    use_preset = act_prog_q[ACT_PRESET] && act_cond_q[ACT_PRESET];
  end

  pad_preset_mem #(
    .AW(PRESET_AW),
    .W(SPEED_W)
  ) u_preset (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .wr_en(preset_wr_en),
    .wr_addr(preset_wr_addr),
    .wr_data(preset_wr_data),
    .rd_addr({{(PRESET_AW-IDX_W){1'b0}}, idx}),
    .rd_data_q(preset_rd)
  );

  // Preset path costs one cycle of table read latency
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      speed_from_preset_q <= 1'b0;
      preset_index_q <= '0;
      speed_ref_q <= RST_SPEED;
    end else begin
      speed_from_preset_q <= use_preset;
      preset_index_q <= idx;
      speed_ref_q <= speed_from_preset_q ? preset_rd : cmd_speed_ref;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/pad_dispatcher_props.sv */
`timescale 1ns/1ps
`default_nettype none
module pad_dispatcher_props (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [pad_pkg::SRC_SEL_W-1:0] digital_out1_source_sel,
  input wire logic hardware_enable_input,
  input wire logic external_trip_config,
  input wire logic [pad_pkg::SPEED_W-1:0] jog_speed_setting,
  input wire logic [pad_pkg::SPEED_W-1:0] cmd_speed_ref,
  input wire logic digital_out1_q,
  input wire logic digital_out2_q,
  input wire logic relay_out1_q,
  input wire logic [2:0] out_owned_q,
  input wire pad_pkg::pad_motion_t motion_q,
  input wire logic [pad_pkg::SPEED_W-1:0] jog_speed_q,
  input wire logic trip_conflict_q,
  input wire logic reset_req_q,
  input wire logic speed_from_preset_q,
  input wire logic [pad_pkg::SPEED_W-1:0] speed_ref_q
);
  import pad_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Pin passes two sync flops and the output register
  sequence s_pin_low;
    !hardware_enable_input [*4];
  endsequence
  sequence s_cmd_path;
    !speed_from_preset_q [*3];
  endsequence
  a_out_gate: assert property ((out_owned_q | {relay_out1_q, digital_out2_q, digital_out1_q}) == out_owned_q)
    else $error("output active while not owned");
  a_own_sel: assert property ($past(digital_out1_source_sel) != SRC_SEL_LOGIC |-> !out_owned_q[0])
    else $error("output owned without logic mode");
  a_jog_excl: assert property (!(motion_q.jog_fwd && motion_q.jog_rev))
    else $error("both jog directions active");
  a_pin_gate: assert property (s_pin_low |-> !motion_q.drive_en)
    else $error("drive enabled with pin low");
  a_reset_once: assert property (reset_req_q |=> !reset_req_q)
    else $error("reset request longer than one cycle");
  a_jog_copy: assert property ($past(arst_n) |-> jog_speed_q == $past(jog_speed_setting))
    else $error("jog speed not passed on");
  a_trip_flag: assert property (trip_conflict_q |-> external_trip_config || $past(external_trip_config))
    else $error("trip conflict without trip config");
  a_cmd_ref: assert property (s_cmd_path |-> speed_ref_q == $past(cmd_speed_ref))
    else $error("speed reference not from command source");
endmodule
bind pad_dispatcher pad_dispatcher_props u_props (.clk_sys, .arst_n, .digital_out1_source_sel,
  .hardware_enable_input, .external_trip_config, .jog_speed_setting, .cmd_speed_ref,
  .digital_out1_q, .digital_out2_q, .relay_out1_q, .out_owned_q, .motion_q, .jog_speed_q,
  .trip_conflict_q, .reset_req_q, .speed_from_preset_q, .speed_ref_q);
`default_nettype wire

/* File: testbench/pad_motor_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pad_motor_model (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire pad_pkg::pad_motion_t motion_q,
  input wire logic [pad_pkg::SPEED_W-1:0] jog_speed_q,
  input wire logic [pad_pkg::SPEED_W-1:0] speed_ref_q,
  output logic [pad_pkg::SPEED_W-1:0] demand_q
);
  import pad_pkg::*;
  // Stop wins over jog, so a double jog never moves the motor
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      demand_q <= RST_SPEED;
    end else if (motion_q.stop || !motion_q.drive_en) begin
      demand_q <= RST_SPEED;
    end else if (motion_q.jog_fwd || motion_q.jog_rev) begin
      demand_q <= jog_speed_q;
    end else begin
      demand_q <= speed_ref_q;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/pad_dispatcher_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module pad_dispatcher_tb_top;
  import pad_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  pad_rule_res_t rule_res = '0;
  logic scan_done = 1'b0;
  logic [SRC_SEL_W-1:0] digital_out1_source_sel = SRC_SEL_LOGIC;
  logic hardware_enable_input = 1'b1;
  logic external_trip_config = 1'b0;
  logic [SPEED_W-1:0] jog_speed_setting = 16'h0123;
  logic [SPEED_W-1:0] cmd_speed_ref = 16'h1234;
  logic preset_wr_en = 1'b0;
  logic [PRESET_AW-1:0] preset_wr_addr = 4'h0;
  logic [SPEED_W-1:0] preset_wr_data = 16'h0000;
  logic digital_out1_q, digital_out2_q, relay_out1_q, logic_fault_q, trip_conflict_q;
  logic reset_req_q, speed_from_preset_q;
  logic [2:0] out_owned_q, preset_index_q;
  pad_motion_t motion_q;
  logic [SPEED_W-1:0] jog_speed_q, speed_ref_q, demand_q;
  int n_mismatch = 0;
  int num_checks = 0;
  int n_pulse = 0;
  // Row: code, cond, motion, {fault, relay, dout2, dout1}, index
  logic [22:0] rows [18] = '{23'h06308, 23'h02300, 23'h0E310, 23'h16320, 23'h20300, 23'h26300,
    23'h2EB00, 23'h37300, 23'h46700, 23'h92300, 23'h9E340, 23'hA2100, 23'hAA200, 23'hB6380,
    23'hCE301, 23'hD6302, 23'hDE304, 23'hE6300};
  pad_dispatcher dut (.clk_sys, .arst_n, .rule_res, .scan_done, .digital_out1_source_sel,
    .digital_out2_source_sel(digital_out1_source_sel),
    .relay_out1_source_sel(digital_out1_source_sel), .hardware_enable_input,
    .external_trip_config, .jog_speed_setting, .cmd_speed_ref, .preset_wr_en, .preset_wr_addr,
    .preset_wr_data, .digital_out1_q, .digital_out2_q, .relay_out1_q, .out_owned_q, .motion_q,
    .jog_speed_q, .logic_fault_q, .trip_conflict_q, .reset_req_q, .speed_from_preset_q,
    .preset_index_q, .speed_ref_q);
  pad_motor_model u_motor (.clk_sys, .arst_n, .motion_q, .jog_speed_q, .speed_ref_q, .demand_q);
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (reset_req_q === 1'b1) n_pulse++;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic rul(input logic [7:0] c, input logic x);
    @(posedge clk_sys);
    rule_res <= {1'b1, c, x};
  endtask
  // Scan ends; the wait covers the preset path, the longest one
  task automatic fin;
    @(posedge clk_sys);
    rule_res <= '0;
    scan_done <= 1'b1;
    @(posedge clk_sys);
    scan_done <= 1'b0;
    repeat (5) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    preset_wr_en <= 1'b1;
    preset_wr_addr <= a;
    preset_wr_data <= d;
    @(posedge clk_sys);
    preset_wr_en <= 1'b0;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk("motion", motion_q, 7'h46);
    chk("index", preset_index_q, 3'h0);
    foreach (rows[i]) begin
      rul(rows[i][22:15], rows[i][14]);
      fin();
      chk("motion", motion_q, rows[i][13:7]);
      chk("outs", {logic_fault_q, relay_out1_q, digital_out2_q, digital_out1_q}, rows[i][6:3]);
      chk("index", preset_index_q, rows[i][2:0]);
      $display("row %0d done", i);
    end
    rul(8'h12, 1'h0);
    rul(8'h06, 1'h1);
    fin();
    chk("jog off", motion_q, 7'h46);
    rul(8'h05, 1'h1);
    rul(8'h06, 1'h1);
    fin();
    chk("jog both", motion_q, 7'h4E);
    rul(8'h06, 1'h1);
    fin();
    chk("demand", demand_q, 16'h0123);
    wr(4'h0, 16'h0AAA);
    wr(4'h3, 16'h0BBB);
    rul(8'h18, 1'h1);
    rul(8'h19, 1'h1);
    rul(8'h1A, 1'h1);
    fin();
    chk("preset", speed_ref_q, 16'h0BBB);
    chk("from preset", speed_from_preset_q, 1'h1);
    chk("jog speed", jog_speed_q, 16'h0123);
    rul(8'h18, 1'h1);
    fin();
    chk("entry0", speed_ref_q, 16'h0AAA);
    rul(8'h18, 1'h0);
    fin();
    chk("cmd", speed_ref_q, 16'h1234);
    chk("no preset", speed_from_preset_q, 1'h0);
    rul(8'h17, 1'h0);
    fin();
    n_pulse = 0;
    rul(8'h17, 1'h1);
    fin();
    chk("pulse", n_pulse, 1);
    rul(8'h17, 1'h1);
    fin();
    chk("held", n_pulse, 1);
    $display("edge tests done");
    @(posedge clk_sys);
    digital_out1_source_sel <= 4'h0;
    rul(8'h00, 1'h1);
    fin();
    chk("not owned", {out_owned_q, digital_out1_q}, 4'h0);
    @(posedge clk_sys);
    digital_out1_source_sel <= SRC_SEL_LOGIC;
    hardware_enable_input <= 1'b0;
    rul(8'h04, 1'h1);
    fin();
    chk("pin low", motion_q.drive_en, 1'h0);
    fin();
    chk("pin only", motion_q.drive_en, 1'h0);
    @(posedge clk_sys);
    hardware_enable_input <= 1'b1;
    external_trip_config <= 1'b1;
    rul(8'h13, 1'h1);
    fin();
    chk("conflict", trip_conflict_q, 1'h1);
    chk("fault", logic_fault_q, 1'h1);
    rul(8'h16, 1'h1);
    fin();
    arst_n <= 1'b0;
    #1;
    chk("in reset", motion_q, 7'h00);
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk("after reset", motion_q, 7'h46);
    $display("hand tests done");
    end_sim();
  end
endmodule
`default_nettype wire
